// [hw/ptfc_consts.vh]
`ifndef PTFC_CONSTS_VH
`define PTFC_CONSTS_VH

// Register byte offsets
`define PTFC_OFS_TIMER_CONFIG 8'h8c
`define PTFC_OFS_TIMER_CURRENT_COUNT 8'h90
`define PTFC_OFS_FREE_COUNTER_VALUE 8'h9c

// Width of the register port address
`define PTFC_ADDR_W 8

// Configuration field positions
`define PTFC_RUN_EN_BIT 29
`define PTFC_PRELOAD_MSB 15
`define PTFC_PRELOAD_LSB 0

// Reset values, and the zero the count wraps from
`define PTFC_PRELOAD_RST 16'hffff
`define PTFC_COUNT_RST 16'hffff
`define PTFC_COUNT_ZERO 16'h0000
`define PTFC_FREE_RST 32'h00000000

// Clock rates in MHz
`define PTFC_REF_MHZ 20
`define PTFC_FREE_MHZ 25

// Timer tick period in microseconds and in reference cycles
`define PTFC_TICK_US 100
`define PTFC_TICK_CYC (`PTFC_TICK_US * `PTFC_REF_MHZ)
`define PTFC_PRESC_W 11

// Free counter advance per reference cycle, whole part and remainder
`define PTFC_FREE_STEP (`PTFC_FREE_MHZ / `PTFC_REF_MHZ)
`define PTFC_FREE_REM (`PTFC_FREE_MHZ % `PTFC_REF_MHZ)
`define PTFC_FRAC_W 5

// Stale read window of the free counter after reset, in ns
`define PTFC_FREE_CLR_NS 160

`endif

// [hw/ptfc_top.v]
// Local design decision: the strobed register port.

`timescale 1ns/1ps
`default_nettype none
`include "ptfc_consts.vh"

module ptfc_top (
  input wire REF_CLK,
  input wire RESET,
  input wire [`PTFC_ADDR_W-1:0] ADDR,
  input wire [31:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  output reg [31:0] RD_DATA,
  input wire WRAP_IRQ_EN,
  input wire WRAP_CLR,
  output reg WRAP_FLAG,
  output reg WRAP_IRQ,
  output reg TIMER_TICK
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Only three words are mapped; everything else reads zero
  // Writes to the read-only words are dropped without a trace
  // No wait states: a strobe is always taken on its own edge

  localparam [`PTFC_ADDR_W-1:0] OFS_CFG = `PTFC_OFS_TIMER_CONFIG;
  localparam [`PTFC_ADDR_W-1:0] OFS_CNT = `PTFC_OFS_TIMER_CURRENT_COUNT;
  localparam [`PTFC_ADDR_W-1:0] OFS_FREE = `PTFC_OFS_FREE_COUNTER_VALUE;

  // Register select, shared by the write and the read path
  // Plain equality; the port carries whole byte offsets
  function ptfc_hit;
    input [`PTFC_ADDR_W-1:0] addr;
    input [`PTFC_ADDR_W-1:0] ofs;
    begin
      ptfc_hit = (addr == ofs);
    end
  endfunction

  wire cfg_wr;
  wire cfg_sel;
  wire cnt_sel;
  wire free_sel;

  // Decode of the three mapped words
  assign cfg_sel = ptfc_hit(ADDR, OFS_CFG);
  assign cnt_sel = ptfc_hit(ADDR, OFS_CNT);
  assign free_sel = ptfc_hit(ADDR, OFS_FREE);
  // Only the configuration word takes writes
  assign cfg_wr = WR_EN & cfg_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Timer configuration
  // Run enable and preload share one word, written as a whole
  // Turning the timer off presets the preload to all ones
  // The count still takes the written preload on that same write
  // A clean restart writes enable and preload together;
  // a separate enable write reloads from the new low bits

  localparam [15:0] PRELOAD_RST = `PTFC_PRELOAD_RST;
  localparam [15:0] COUNT_RST = `PTFC_COUNT_RST;
  localparam [15:0] COUNT_ZERO = `PTFC_COUNT_ZERO;

  reg run_en_q;
  reg run_en_d;
  reg [15:0] preload_q;
  reg [15:0] preload_d;
  wire wr_run_en;
  wire [15:0] wr_preload;
  wire run_fall;

  // Fields of a configuration write
  assign wr_run_en = WR_DATA[`PTFC_RUN_EN_BIT];
  assign wr_preload = WR_DATA[`PTFC_PRELOAD_MSB:`PTFC_PRELOAD_LSB];
  // A write that turns the timer off
  assign run_fall = cfg_wr & run_en_q & ~wr_run_en;

  // Next configuration; disabling overrides the written preload
  always @* begin
    run_en_d = run_en_q;
    preload_d = preload_q;
    if (cfg_wr) begin
      run_en_d = wr_run_en;
      preload_d = wr_preload;
      if (run_fall) begin
        preload_d = PRELOAD_RST;
      end
    end
  end

  // Run enable flop, off after reset
  always @(posedge REF_CLK) begin
    if (RESET) begin
      run_en_q <= 1'b0;
    end else begin
      run_en_q <= run_en_d;
    end
  end

  // Preload flop, back to all ones on reset
  always @(posedge REF_CLK) begin
    if (RESET) begin
      preload_q <= PRELOAD_RST;
    end else begin
      preload_q <= preload_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescaler
  // One tick every 100 us of the 20 MHz reference
  // Held at zero while stopped, so a restart never gives a short step
  // Trade-off: a write late in a period loses that partial period

  // Tick length kept as integer, then cut to the counter width
  localparam integer PRESC_LAST_I = `PTFC_TICK_CYC - 1;
  localparam [`PTFC_PRESC_W-1:0] PRESC_LAST =
    PRESC_LAST_I[`PTFC_PRESC_W-1:0];
  localparam [`PTFC_PRESC_W-1:0] PRESC_ZERO = {`PTFC_PRESC_W{1'b0}};
  localparam [`PTFC_PRESC_W-1:0] PRESC_ONE = {{(`PTFC_PRESC_W-1){1'b0}}, 1'b1};

  reg [`PTFC_PRESC_W-1:0] presc_q;
  reg [`PTFC_PRESC_W-1:0] presc_d;
  reg tick_d;

  // Restart on every load so the first step is a full period
  always @* begin
    presc_d = presc_q;
    tick_d = 1'b0;
    if (cfg_wr || !run_en_q) begin
      presc_d = PRESC_ZERO;
    end else if (presc_q == PRESC_LAST) begin
      presc_d = PRESC_ZERO;
      tick_d = 1'b1;
    end else begin
      presc_d = presc_q + PRESC_ONE;
    end
  end

  // Prescaler flop
  always @(posedge REF_CLK) begin
    if (RESET) begin
      presc_q <= PRESC_ZERO;
    end else begin
      presc_q <= presc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down counter
  // Steps only on the prescaler tick, never on a bare clock
  // Wrap to all ones happens on the tick that finds zero
  // A write in the tick cycle wins and the tick is dropped
  // Keeps counting through a wrap; no stop state exists

  reg [15:0] count_q;
  reg [15:0] count_d;
  reg wrap_ev;

  // A write always wins over a tick in the same cycle
  always @* begin
    count_d = count_q;
    wrap_ev = 1'b0;
    if (cfg_wr) begin
      // Covers both the enable load and a preload write
      count_d = wr_preload;
    end else if (tick_d) begin
      if (count_q == COUNT_ZERO) begin
        count_d = COUNT_RST;
        wrap_ev = 1'b1;
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  // Count flop
  always @(posedge REF_CLK) begin
    if (RESET) begin
      count_q <= COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap flag and interrupt request
  // Flag is sticky; only a clear request takes it down
  // Set wins over clear so that a wrap is never lost
  // Request is a level that follows the flag and the enable
  // Status logic outside does the final masking and acknowledge

  reg wrap_d;

  // A wrap in the clearing cycle keeps the flag set
  always @* begin
    wrap_d = WRAP_FLAG;
    if (WRAP_CLR) begin
      wrap_d = 1'b0;
    end
    if (wrap_ev) begin
      wrap_d = 1'b1;
    end
  end

  // Flag is a level for the status logic outside
  always @(posedge REF_CLK) begin
    if (RESET) begin
      WRAP_FLAG <= 1'b0;
    end else begin
      WRAP_FLAG <= wrap_d;
    end
  end

  // Request rises with the flag, gated by the enable
  always @(posedge REF_CLK) begin
    if (RESET) begin
      WRAP_IRQ <= 1'b0;
    end else begin
      WRAP_IRQ <= wrap_d & WRAP_IRQ_EN;
    end
  end

  // Tick strobe for debug, registered on the same edge as the count step
  always @(posedge REF_CLK) begin
    if (RESET) begin
      TIMER_TICK <= 1'b0;
    end else begin
      TIMER_TICK <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free counter

  localparam [31:0] FREE_RST = `PTFC_FREE_RST;
  localparam [31:0] FREE_STEP = `PTFC_FREE_STEP;
  localparam integer FRAC_REM_I = `PTFC_FREE_REM;
  localparam integer FRAC_MOD_I = `PTFC_REF_MHZ;
  localparam [`PTFC_FRAC_W-1:0] FRAC_REM = FRAC_REM_I[`PTFC_FRAC_W-1:0];
  localparam [`PTFC_FRAC_W-1:0] FRAC_MOD = FRAC_MOD_I[`PTFC_FRAC_W-1:0];
  localparam [`PTFC_FRAC_W-1:0] FRAC_ZERO = {`PTFC_FRAC_W{1'b0}};

  reg [31:0] free_q;
  reg [31:0] free_d;
  reg [`PTFC_FRAC_W-1:0] frac_q;
  reg [`PTFC_FRAC_W-1:0] frac_d;
  reg [`PTFC_FRAC_W:0] frac_sum;

  // Rate ratio 25/20: one step per cycle plus one extra every fourth
  // Accumulator carries the remainder so no drift builds up
  // Limitation: reads one cycle apart may differ by one or two
  // Counter clears on the reset edge, well inside the allowed window
  // No flag, request or strobe leaves this section
  // The 25 MHz rate is faster than the reference, so the counter
  // advances by the rate ratio each cycle; the remainder is carried
  // in a phase accumulator. Reads are exact only on average.
  always @* begin
    frac_sum = {1'b0, frac_q} + {1'b0, FRAC_REM};
    frac_d = frac_sum[`PTFC_FRAC_W-1:0];
    free_d = free_q + FREE_STEP;
    if (frac_sum >= {1'b0, FRAC_MOD}) begin
      frac_d = frac_sum[`PTFC_FRAC_W-1:0] - FRAC_MOD;
      free_d = free_q + FREE_STEP + 32'h00000001;
    end
  end

  // Natural 32-bit wrap gives the rollover; no event leaves here
  always @(posedge REF_CLK) begin
    if (RESET) begin
      free_q <= FREE_RST;
    end else begin
      free_q <= free_d;
    end
  end

  // Phase accumulator restarts with the counter
  always @(posedge REF_CLK) begin
    if (RESET) begin
      frac_q <= FRAC_ZERO;
    end else begin
      frac_q <= frac_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // One shared decode for both strobes keeps reads and writes aligned
  // Read data are registered and return to zero after one cycle
  // Zero when idle, so a stale word is never mistaken for a read
  // Reserved bits are tied low rather than stored

  reg [31:0] rd_d;

  // Unmapped and reserved bits read as zero
  always @* begin
    rd_d = 32'h00000000;
    if (cfg_sel) begin
      rd_d[`PTFC_RUN_EN_BIT] = run_en_q;
      rd_d[`PTFC_PRELOAD_MSB:`PTFC_PRELOAD_LSB] = preload_q;
    end else if (cnt_sel) begin
      rd_d[15:0] = count_q;
    end else if (free_sel) begin
      rd_d = free_q;
    end
  end

  // Data stand only in the cycle after the strobe
  always @(posedge REF_CLK) begin
    if (RESET) begin
      RD_DATA <= 32'h00000000;
    end else if (RD_EN) begin
      RD_DATA <= rd_d;
    end else begin
      RD_DATA <= 32'h00000000;
    end
  end

endmodule // ptfc_top

`default_nettype wire

// [verification/ptfc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ptfc_chk (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [31:0] RD_DATA,
  input wire logic WRAP_IRQ_EN,
  input wire logic WRAP_CLR,
  input wire logic WRAP_FLAG,
  input wire logic WRAP_IRQ,
  input wire logic TIMER_TICK
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  logic [11:0] gap_q;
  logic [15:0] pre_q;
  // Cycles since last tick or config write, saturating
  always @(posedge REF_CLK) begin
    if (RESET || TIMER_TICK || (WR_EN && ADDR == 8'h8c)) gap_q <= 12'h000;
    else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
    if (WR_EN && ADDR == 8'h8c) pre_q <= WR_DATA[15:0];
  end
  property p_rd_idle; !$past(RD_EN) |-> RD_DATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_cnt_hi;
    $past(RD_EN) && $past(ADDR) == 8'h90 |-> RD_DATA[31:16] == 16'h0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count upper set");
  property p_cfg_rsvd; $past(RD_EN) && $past(ADDR) == 8'h8c |->
    RD_DATA[31:30] == 2'h0 && RD_DATA[28:16] == 13'h0;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config rsvd");
  property p_load;
    WR_EN && ADDR == 8'h8c ##1 RD_EN && ADDR == 8'h90 |=> RD_DATA[15:0] == pre_q;
  endproperty
  a_load: assert property (p_load) else $error("preload not loaded");
  property p_sticky; WRAP_FLAG && !WRAP_CLR |=> WRAP_FLAG; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  // A wrap in the clear cycle wins; it shows as a tick next cycle
  property p_clear;
    WRAP_CLR && WRAP_FLAG |=> !WRAP_FLAG || TIMER_TICK;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_irq; WRAP_IRQ == (WRAP_FLAG && $past(WRAP_IRQ_EN)); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_tick_gap; TIMER_TICK |-> gap_q >= 12'h7cf; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick early");
  property p_free_step; $past(RD_EN, 2) && $past(ADDR, 2) == 8'h9c &&
    $past(RD_EN) && $past(ADDR) == 8'h9c |->
    (RD_DATA - $past(RD_DATA)) inside {32'h1, 32'h2};
  endproperty
  a_free_step: assert property (p_free_step) else $error("free step");
  c_wrap: cover property ($rose(WRAP_FLAG));
  c_irq: cover property ($rose(WRAP_IRQ));
  c_tick: cover property (TIMER_TICK);
endmodule // ptfc_chk
bind ptfc_top ptfc_chk u_ptfc_chk (.REF_CLK(REF_CLK), .RESET(RESET),
  .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RD_DATA(RD_DATA), .WRAP_IRQ_EN(WRAP_IRQ_EN), .WRAP_CLR(WRAP_CLR),
  .WRAP_FLAG(WRAP_FLAG), .WRAP_IRQ(WRAP_IRQ), .TIMER_TICK(TIMER_TICK));
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, irq_en = 0, clr = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rv, r1;
  wire [31:0] rd_data;
  wire flag, irq;
  int num_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  ptfc_top u_ptfc_top (.REF_CLK(clk), .RESET(rst), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .WRAP_IRQ_EN(irq_en), .WRAP_CLR(clr), .WRAP_FLAG(flag), .WRAP_IRQ(irq),
    .TIMER_TICK());
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Every call must be followed by another, so a strobe never lingers
  task acc(input logic w, input logic r, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= d;
  endtask
  task idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task rd(input logic [7:0] a);
    acc(1'b0, 1'b1, a, 32'h0);
    idle(1);
    #1 rv = rd_data;
  endtask
  task wclr;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    #1;
  endtask
  task end_of_test;
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: run needs about 8200 cycles
  initial begin
    #1000000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h8c);
    chk(rv, 32'h0000ffff);
    rd(8'h90);
    chk(rv, 32'h0000ffff);
    rd(8'h9c);
    chk({31'h0, rv < 32'h20}, 32'h1);
    rd(8'h80);
    chk(rv, 32'h0);
    // Count word ignores writes
    acc(1'b1, 1'b0, 8'h90, 32'h1234);
    rd(8'h90);
    chk(rv, 32'h0000ffff);
    acc(1'b1, 1'b0, 8'h8c, 32'h20000001);
    rd(8'h90);
    chk(rv, 32'h1);
    @(posedge clk) irq_en <= 1'b1;
    rd(8'h8c);
    chk(rv, 32'h20000001);
    idle(1980);
    rd(8'h90);
    chk(rv, 32'h1);
    idle(20);
    rd(8'h90);
    chk(rv, 32'h0);
    idle(2010);
    chk({31'h0, flag}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(8'h90);
    chk(rv, 32'h0000ffff);
    idle(5);
    chk({31'h0, flag}, 32'h1);
    wclr;
    chk({31'h0, flag}, 32'h0);
    // Masked wrap still flags but must not interrupt
    @(posedge clk) irq_en <= 1'b0;
    acc(1'b1, 1'b0, 8'h8c, 32'h20000000);
    idle(2010);
    chk({31'h0, flag}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wclr;
    acc(1'b1, 1'b0, 8'h8c, 32'h5);
    rd(8'h8c);
    chk(rv, 32'h0000ffff);
    rd(8'h90);
    chk(rv, 32'h5);
    idle(2050);
    rd(8'h90);
    chk(rv, 32'h5);
    rd(8'h9c);
    r1 = rv;
    idle(98);
    rd(8'h9c);
    chk(rv - r1, 32'h7d);
    acc(1'b0, 1'b1, 8'h9c, 32'h0);
    acc(1'b0, 1'b1, 8'h9c, 32'h0);
    // Preload away from all ones, so the reset below has work to do
    acc(1'b1, 1'b0, 8'h8c, 32'h1234);
    idle(2);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h9c);
    chk({31'h0, rv < 32'h20}, 32'h1);
    rd(8'h8c);
    chk(rv, 32'h0000ffff);
    rd(8'h90);
    chk(rv, 32'h0000ffff);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
